// file: oss_sequencer.sv
// Output step sequencer: mode machine, step timing, loops and output values
`timescale 1ns/1ps
`include "oss_defines.svh"
module oss_sequencer
  import oss_pkg::*;
#(
  parameter int STEPS   = 256,            // Step table entries (0 is the idle step, run only on resume after an end-action hold at step 255)
  parameter int TIME_W  = 24              // Step time width in 0.1 ms ticks
) (
  input  wire logic               core_clk_i,      // System clock
  input  wire logic               rst_i,           // Synchronous reset, high
  input  wire logic               output_on_i,     // Main output enabled
  input  wire logic               cmd_start_i,     // Start command pulse
  input  wire logic               cmd_hold_i,      // Hold command pulse
  input  wire logic               cmd_stop_i,      // Stop command pulse
  input  wire logic               cmd_branch_i,    // Branch command pulse
  input  wire logic               phase_zero_i,    // AC phase crossed zero (pin)
  input  wire logic               wr_en_i,         // Step table write strobe
  input  wire logic [7:0]         wr_step_i,       // Step number to write
  input  wire logic signed [15:0] wr_dc_i,         // DC target, 0.1 V
  input  wire logic [15:0]        wr_ac_i,         // AC target, 0.1 V
  input  wire logic [15:0]        wr_freq_i,       // Frequency, 0.1 Hz
  input  wire logic [1:0]         wr_op_i,         // Operation type
  input  wire logic [4:0]         wr_wave_i,       // 0 tone,1 rect,2..17 user_wave_slot
  input  wire logic [11:0]        wr_phase_i,      // Start phase, 0.1 deg
  input  wire logic [1:0]         wr_sync_i,       // Sync output code
  input  wire logic [TIME_W-1:0]  wr_time_i,       // Step time in 0.1 ms
  input  wire logic               wr_endph_i,      // End-phase wait enable
  input  wire logic [1:0]         wr_act_i,        // End action
  input  wire logic [7:0]         wr_jump_i,       // Jump target
  input  wire logic [9:0]         wr_jcnt_i,       // Jump count
  input  wire logic [7:0]         wr_branch_i,     // Branch target
  output logic [1:0]              mode_o,          // 0 idle,1 run,2 hold
  output logic [7:0]              step_o,          // Current step
  output logic signed [15:0]      dc_o,            // Present DC output
  output logic [15:0]             ac_o,            // Present AC output
  output logic [15:0]             freq_o,          // Present frequency
  output logic [4:0]              wave_o,          // Present waveform
  output logic [11:0]             phase_o,         // Present start phase
  output logic [1:0]              sync_o,          // Step synchronized output
  output logic                    force_off_o      // Pulse: switch output off
);
  // ==================================================
  // Timing constants
  localparam int TICK_CYC = `OSS_TICK_NS / `OSS_CLK_NS;  // Cycles per 0.1 ms

  // ==================================================
  // Step table memory
  logic signed [15:0] t_dc   [STEPS];
  logic [15:0]        t_ac   [STEPS];
  logic [15:0]        t_freq [STEPS];
  logic [1:0]         t_op   [STEPS];
  logic [4:0]         t_wave [STEPS];
  logic [11:0]        t_ph   [STEPS];
  logic [1:0]         t_sync [STEPS];
  logic [TIME_W-1:0]  t_time [STEPS];
  logic               t_endp [STEPS];
  logic [1:0]         t_act  [STEPS];
  logic [7:0]         t_jmp  [STEPS];
  logic [9:0]         t_jcnt [STEPS];
  logic [7:0]         t_br   [STEPS];
  logic [9:0]         jctr   [STEPS];     // Per-step jump counters

  // ==================================================
  // State of the sequencer
  typedef struct packed {
    oss_mode_t          mode;
    oss_phase_t         ph;
    logic               act_hold;     // Hold came from end action
    logic [7:0]         step;
    logic [7:0]         resume;       // Step for start after end-action hold
    logic [15:0]        tick;
    logic [TIME_W-1:0]  elapsed;
    logic signed [15:0] dc;
    logic [15:0]        ac;
    logic [15:0]        freq;
    logic signed [15:0] dc0;          // Values at step entry, sweep origin
    logic [15:0]        ac0;
    logic [15:0]        freq0;
    logic [4:0]         wave;
    logic [11:0]        phase;
    logic [1:0]         sync;
    logic               off;
    logic               enter;        // Load new step next cycle
    logic               pz_s1;
    logic               pz_s2;
  } oss_state_t;

  oss_state_t s_r, s_nxt;
  logic        cnt_wr;                // Jump counter update strobe
  logic [9:0]  cnt_val;
  logic [7:0]  cnt_idx;
  logic        cnt_clr_all;

  // Linear interpolation from entry value to target
  function automatic logic signed [15:0] lerp(input logic signed [16:0] a,
      input logic signed [16:0] b, input logic [TIME_W-1:0] e,
      input logic [TIME_W-1:0] t);
    logic signed [47:0] d;
    d = 48'(b - a) * $signed({1'b0, e});
    if (t == '0) begin
      lerp = b[15:0];
    end else begin
      lerp = 16'(a + 17'(d / $signed({1'b0, t})));
    end
  endfunction

  // ==================================================
  // Next-state logic
  always_comb begin
    logic       done;
    logic       cmd_ok;
    logic [7:0] nxt;
    logic [7:0] cur;
    done = 1'b0;
    cmd_ok = output_on_i;
    nxt = 8'h00;
    cur = s_r.step;
    s_nxt = s_r;
    s_nxt.off = 1'b0;
    s_nxt.enter = 1'b0;
    cnt_wr = 1'b0;
    cnt_val = 10'h000;
    cnt_idx = cur;
    cnt_clr_all = 1'b0;
    s_nxt.pz_s1 = phase_zero_i;
    s_nxt.pz_s2 = s_r.pz_s1;
    // Load the entered step's parameters
    if (s_r.enter) begin
      s_nxt.dc0 = s_r.dc;
      s_nxt.ac0 = s_r.ac;
      s_nxt.freq0 = s_r.freq;
      s_nxt.sync = t_sync[cur];
      if (t_op[cur] == `OSS_OP_FIXED) begin
        s_nxt.dc = t_dc[cur];
        s_nxt.ac = t_ac[cur];
        s_nxt.freq = t_freq[cur];
      end
      if (t_op[cur] != `OSS_OP_KEEP) begin
        s_nxt.wave = t_wave[cur];
        s_nxt.phase = t_ph[cur];
      end
    end
    case (s_r.mode)
      OSS_IDLE: begin
        s_nxt.sync = 2'h0;
        if (cmd_ok && cmd_start_i) begin
          s_nxt.mode = OSS_RUN;
          s_nxt.step = `OSS_STEP_FIRST;
          s_nxt.enter = 1'b1;
          s_nxt.ph = OSS_TIMING;
          s_nxt.tick = '0;
          s_nxt.elapsed = '0;
          cnt_clr_all = 1'b1;
        end
      end
      OSS_RUN: begin
        if (!s_r.enter) begin
          // Sweep tracks elapsed time
          if (t_op[cur] == `OSS_OP_SWEEP && s_r.ph == OSS_TIMING) begin
            s_nxt.dc = lerp(17'(s_r.dc0), 17'(t_dc[cur]), s_r.elapsed, t_time[cur]);
            s_nxt.ac = lerp({1'b0, s_r.ac0}, {1'b0, t_ac[cur]}, s_r.elapsed, t_time[cur]);
            s_nxt.freq = lerp({1'b0, s_r.freq0}, {1'b0, t_freq[cur]},
                              s_r.elapsed, t_time[cur]);
          end
          // Step timing
          if (s_r.ph == OSS_TIMING) begin
            if (s_r.tick == 16'(TICK_CYC - 1)) begin
              s_nxt.tick = '0;
              s_nxt.elapsed = s_r.elapsed + 1'b1;
              if (s_r.elapsed + 1'b1 >= t_time[cur]) begin
                s_nxt.ph = t_endp[cur] ? OSS_PHASE_WAIT : OSS_FINISH;
                if (t_op[cur] == `OSS_OP_SWEEP) begin
                  s_nxt.dc = t_dc[cur];
                  s_nxt.ac = t_ac[cur];
                  s_nxt.freq = t_freq[cur];
                end
              end
            end else begin
              s_nxt.tick = s_r.tick + 1'b1;
            end
          end else if (s_r.ph == OSS_PHASE_WAIT) begin
            if (s_r.pz_s2) begin
              s_nxt.ph = OSS_FINISH;
            end
          end else begin
            done = 1'b1;
          end
        end
        // Work out the following step
        if (t_jmp[cur] == 8'h00) begin
          nxt = cur + 1'b1;
        end else if (t_jcnt[cur] == `OSS_JUMP_FOREVER) begin
          nxt = t_jmp[cur];
        end else if (jctr[cur] >= t_jcnt[cur]) begin
          nxt = cur + 1'b1;
        end else begin
          nxt = t_jmp[cur];
        end
        if (cmd_ok && cmd_stop_i) begin
          s_nxt.mode = OSS_IDLE;
        end else if (cmd_ok && cmd_hold_i) begin
          s_nxt.mode = OSS_HOLD;
          s_nxt.act_hold = 1'b0;
        end else if (cmd_ok && cmd_branch_i && t_br[cur] != 8'h00) begin
          s_nxt.step = t_br[cur];
          s_nxt.enter = 1'b1;
          s_nxt.ph = OSS_TIMING;
          s_nxt.tick = '0;
          s_nxt.elapsed = '0;
        end else if (done) begin
          if (t_jmp[cur] != 8'h00 && t_jcnt[cur] != `OSS_JUMP_FOREVER) begin
            cnt_wr = 1'b1;
            cnt_val = (jctr[cur] >= t_jcnt[cur]) ? 10'h000 : jctr[cur] + 1'b1;
          end
          s_nxt.ph = OSS_TIMING;
          s_nxt.tick = '0;
          s_nxt.elapsed = '0;
          if (t_act[cur] == `OSS_ACT_IDLE) begin
            s_nxt.mode = OSS_IDLE;
          end else if (t_act[cur] == `OSS_ACT_HOLD) begin
            s_nxt.mode = OSS_HOLD;
            s_nxt.act_hold = 1'b1;
            s_nxt.resume = nxt;
          end else if (cur == `OSS_STEP_MAX) begin
            s_nxt.mode = OSS_IDLE;
          end else begin
            s_nxt.step = nxt;
            s_nxt.enter = 1'b1;
          end
        end
      end
      default: begin
        // Hold keeps output frozen until start resumes the run or a branch loads the target step's values
        if (cmd_ok && cmd_stop_i) begin
          s_nxt.mode = OSS_IDLE;
        end else if (cmd_ok && cmd_start_i) begin
          s_nxt.mode = OSS_RUN;
          if (s_r.act_hold) begin
            s_nxt.step = s_r.resume;
            s_nxt.enter = 1'b1;
          end
        end else if (cmd_ok && cmd_branch_i && t_br[cur] != 8'h00) begin
          s_nxt.step = t_br[cur];
          s_nxt.enter = 1'b1;
          s_nxt.act_hold = 1'b0;
          s_nxt.elapsed = '0;
          s_nxt.tick = '0;
          s_nxt.ph = OSS_TIMING;
        end
      end
    endcase
    // Stop clamping of retained values
    if (s_r.mode != OSS_IDLE && s_nxt.mode == OSS_IDLE) begin
      s_nxt.step = 8'h00;
      if (s_r.dc < `OSS_DC_MIN || s_r.dc > `OSS_DC_MAX || s_r.ac > `OSS_AC_MAX) begin
        s_nxt.dc = 16'sh0000;
        s_nxt.ac = 16'h0000;
        s_nxt.off = 1'b1;
      end
      if (s_r.freq < `OSS_FREQ_MIN || s_r.freq > `OSS_FREQ_MAX) begin
        s_nxt.freq = `OSS_FREQ_MIN;
        s_nxt.off = 1'b1;
      end
    end
    if (s_nxt.mode == OSS_IDLE) begin
      s_nxt.sync = 2'h0;
    end
  end

  // ==================================================
  // Step table and jump counters
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      t_dc[wr_step_i] <= wr_dc_i;
      t_ac[wr_step_i] <= wr_ac_i;
      t_freq[wr_step_i] <= wr_freq_i;
      t_op[wr_step_i] <= wr_op_i;
      t_wave[wr_step_i] <= wr_wave_i;
      t_ph[wr_step_i] <= wr_phase_i;
      t_sync[wr_step_i] <= wr_sync_i;
      t_time[wr_step_i] <= wr_time_i;
      t_endp[wr_step_i] <= wr_endph_i;
      t_act[wr_step_i] <= wr_act_i;
      t_jmp[wr_step_i] <= wr_jump_i;
      t_jcnt[wr_step_i] <= wr_jcnt_i;
      t_br[wr_step_i] <= wr_branch_i;
    end
    for (int i = 0; i < STEPS; i++) begin
      if (rst_i || cnt_clr_all) begin
        jctr[i] <= 10'h000;
      end else if (cnt_wr && cnt_idx == 8'(i)) begin
        jctr[i] <= cnt_val;
      end
    end
  end

  // ==================================================
  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_r <= '{mode: OSS_IDLE, ph: OSS_TIMING, freq: `OSS_FREQ_MIN, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mode_o = s_r.mode;
  assign step_o = s_r.step;
  assign dc_o = s_r.dc;
  assign ac_o = s_r.ac;
  assign freq_o = s_r.freq;
  assign wave_o = s_r.wave;
  assign phase_o = s_r.phase;
  assign sync_o = s_r.sync;
  assign force_off_o = s_r.off;

  // ==================================================
  // Assertions
  a_idle_sync_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_r.mode == OSS_IDLE |-> sync_o == 2'h0) else $error("sync not low in idle");
  a_start_step_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_r.mode == OSS_IDLE && output_on_i && cmd_start_i) |=> (step_o == 8'h01 &&
    mode_o == OSS_RUN)) else $error("start did not enter step one");
  a_off_rejects: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!output_on_i && !s_r.enter && s_r.ph != OSS_FINISH) |=> $stable(s_r.mode))
    else $error("command taken with output off");
  a_hold_cmd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_r.mode == OSS_RUN && output_on_i && cmd_hold_i && !cmd_stop_i) |=> mode_o == OSS_HOLD)
    else $error("hold not entered");
  a_stop_cmd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_r.mode != OSS_IDLE && output_on_i && cmd_stop_i) |=>
    (mode_o == OSS_IDLE && step_o == 8'h00)) else $error("stop not applied");
  a_hold_frozen: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_r.mode == OSS_HOLD && !s_r.enter && !cmd_start_i && !cmd_stop_i) |=> $stable(dc_o))
    else $error("output moved in hold");
  a_wait_keeps: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_r.mode == OSS_RUN && s_r.ph == OSS_PHASE_WAIT && !cmd_stop_i && !cmd_branch_i)
    |=> $stable(dc_o)) else $error("settings moved in phase wait");
  a_freq_clamp: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_r.mode != OSS_IDLE && s_nxt.mode == OSS_IDLE && (s_r.freq < `OSS_FREQ_MIN ||
    s_r.freq > `OSS_FREQ_MAX)) |=> (freq_o == `OSS_FREQ_MIN && force_off_o))
    else $error("frequency not clamped");
endmodule

// file: oss_defines.svh
// Constants for the output step sequencer
`ifndef OSS_DEFINES_SVH
`define OSS_DEFINES_SVH
`define OSS_CLK_HZ      100000000
`define OSS_TICK_NS     100000
`define OSS_CLK_NS      10
`define OSS_STEP_MAX    8'hff
`define OSS_STEP_FIRST  8'h01
`define OSS_JUMP_FOREVER 10'h000
`define OSS_DC_MIN      16'sheed0
`define OSS_DC_MAX      16'sh1130
`define OSS_AC_MAX      16'h0d70
`define OSS_FREQ_MIN    16'h000a
`define OSS_FREQ_MAX    16'h157c
`define OSS_ACT_PROCEED 2'h0
`define OSS_ACT_HOLD    2'h1
`define OSS_ACT_IDLE    2'h2
`define OSS_OP_FIXED    2'h0
`define OSS_OP_KEEP     2'h1
`define OSS_OP_SWEEP    2'h2
`endif

// file: oss_pkg.sv
// Types shared by the output step sequencer
package oss_pkg;
  typedef enum logic [1:0] {OSS_IDLE, OSS_RUN, OSS_HOLD} oss_mode_t;
  typedef enum logic [1:0] {OSS_TIMING, OSS_PHASE_WAIT, OSS_FINISH} oss_phase_t;
endpackage

// file: oss_host_model.sv
// Host controller model: main output switch and sequence command pulses
`timescale 1ns/1ps
module oss_host_model (
  input  wire logic core_clk_i,   // System clock
  output logic      output_on_o,  // Main output switched on
  output logic      cmd_start_o,  // Start command pulse
  output logic      cmd_hold_o,   // Hold command pulse
  output logic      cmd_stop_o,   // Stop command pulse
  output logic      cmd_branch_o  // Branch command pulse
);
  // ==========================================================
  // Idle levels from time zero
  initial begin
    output_on_o  = 1'b0;
    cmd_start_o  = 1'b0;
    cmd_hold_o   = 1'b0;
    cmd_stop_o   = 1'b0;
    cmd_branch_o = 1'b0;
  end

  // Switch the main output off the sampling edge
  task automatic power(input logic on);
    @(negedge core_clk_i);
    output_on_o = on;
  endtask

  // One-cycle pulse: 0 start, 1 hold, 2 stop, 3 branch
  task automatic send(input logic [1:0] k);
    @(negedge core_clk_i);
    cmd_start_o  = (k == 2'h0);
    cmd_hold_o   = (k == 2'h1);
    cmd_stop_o   = (k == 2'h2);
    cmd_branch_o = (k == 2'h3);
    @(negedge core_clk_i);
    cmd_start_o  = 1'b0;
    cmd_hold_o   = 1'b0;
    cmd_stop_o   = 1'b0;
    cmd_branch_o = 1'b0;
  endtask
endmodule

// file: oss_sequencer_bench.sv
// Self-checking bench for the output step sequencer
`timescale 1ns/1ps
`include "oss_defines.svh"
module oss_sequencer_bench;
  // ==========================================================
  // Stimulus and observed signals
  logic               core_clk_i, rst_i, phase_zero_i, wr_en_i, wr_endph_i;
  logic               on_w, st_w, ho_w, sp_w, br_w, force_off_o;
  logic [7:0]         wr_step_i, wr_jump_i, wr_branch_i, step_o;
  logic signed [15:0] wr_dc_i, dc_o;
  logic [15:0]        wr_ac_i, wr_freq_i, ac_o, freq_o;
  logic [1:0]         wr_op_i, wr_sync_i, wr_act_i, mode_o, sync_o;
  logic [4:0]         wr_wave_i, wave_o;
  logic [11:0]        wr_phase_i, phase_o;
  logic [23:0]        wr_time_i;
  logic [9:0]         wr_jcnt_i;
  int                 n_fail = 0, n_checks = 0, cyc = 0, held = 0, n_off = 0, n, t0;

  oss_host_model i_host (.core_clk_i(core_clk_i), .output_on_o(on_w), .cmd_start_o(st_w),
    .cmd_hold_o(ho_w), .cmd_stop_o(sp_w), .cmd_branch_o(br_w));

  oss_sequencer i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .output_on_i(on_w),
    .cmd_start_i(st_w), .cmd_hold_i(ho_w), .cmd_stop_i(sp_w), .cmd_branch_i(br_w),
    .phase_zero_i(phase_zero_i), .wr_en_i(wr_en_i), .wr_step_i(wr_step_i),
    .wr_dc_i(wr_dc_i), .wr_ac_i(wr_ac_i), .wr_freq_i(wr_freq_i), .wr_op_i(wr_op_i),
    .wr_wave_i(wr_wave_i), .wr_phase_i(wr_phase_i), .wr_sync_i(wr_sync_i),
    .wr_time_i(wr_time_i), .wr_endph_i(wr_endph_i), .wr_act_i(wr_act_i),
    .wr_jump_i(wr_jump_i), .wr_jcnt_i(wr_jcnt_i), .wr_branch_i(wr_branch_i),
    .mode_o(mode_o), .step_o(step_o), .dc_o(dc_o), .ac_o(ac_o), .freq_o(freq_o),
    .wave_o(wave_o), .phase_o(phase_o), .sync_o(sync_o), .force_off_o(force_off_o));

  // Clock, 10 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Cycle, hold-time and output-off pulse counters
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (mode_o === 2'h2) held <= held + 1;
    if (force_off_o === 1'b1) n_off <= n_off + 1;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // Write one step; step time in 0.1 ms ticks
  task automatic wr(input logic [7:0] s, input logic signed [15:0] dc, input logic [15:0] fr,
      input logic [1:0] op, input logic [4:0] wv, input logic [1:0] sy, input logic ep,
      input logic [1:0] act, input logic [7:0] jmp, input logic [9:0] jc, input logic [7:0] br,
      input logic [23:0] tm);
    @(negedge core_clk_i);
    wr_en_i = 1'b1;
    wr_step_i = s;
    wr_dc_i = dc;
    wr_ac_i = {8'h01, s};
    wr_freq_i = fr;
    wr_op_i = op;
    wr_wave_i = wv;
    wr_phase_i = {4'h0, s};
    wr_sync_i = sy;
    wr_time_i = tm;
    wr_endph_i = ep;
    wr_act_i = act;
    wr_jump_i = jmp;
    wr_jcnt_i = jc;
    wr_branch_i = br;
    @(negedge core_clk_i);
    wr_en_i = 1'b0;
  endtask

  // Wait, bounded, until the given step is current
  task automatic go(input logic [7:0] s, input int lim, output int k);
    k = 0;
    while (step_o !== s && k < lim) begin
      @(negedge core_clk_i);
      k++;
    end
    if (step_o !== s) begin
      n_fail++;
      $display("[FAIL] %0t step %0d not reached", $time, s);
    end
  endtask

  // Verdict and end of run
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (98000) @(posedge core_clk_i);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rst_i, phase_zero_i, wr_en_i, wr_endph_i} = 4'h8;
    {wr_step_i, wr_jump_i, wr_branch_i, wr_dc_i, wr_ac_i, wr_freq_i} = '0;
    {wr_op_i, wr_sync_i, wr_act_i, wr_wave_i, wr_phase_i, wr_time_i, wr_jcnt_i} = '0;
    repeat (10) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk(mode_o === 2'h0 && step_o === 8'h00 && sync_o === 2'h0, "reset mode");
    chk(freq_o === 16'h000a && dc_o === 16'sh0000, "reset values");
    wr(8'h01, 16'sh0064, 16'h01f4, `OSS_OP_FIXED, 5'h00, 2'h1, 1'b0, `OSS_ACT_PROCEED,
       8'h00, 10'h000, 8'h00, 24'h000001);
    wr(8'h02, 16'sh03e7, 16'h0200, `OSS_OP_KEEP, 5'h01, 2'h2, 1'b0, `OSS_ACT_PROCEED,
       8'h00, 10'h000, 8'h03, 24'h000001);
    wr(8'h03, 16'sh012c, 16'h01f4, `OSS_OP_SWEEP, 5'h01, 2'h3, 1'b0, `OSS_ACT_HOLD,
       8'h05, 10'h000, 8'h00, 24'h000002);
    wr(8'h05, 16'sh0032, 16'h0064, `OSS_OP_FIXED, 5'h01, 2'h1, 1'b0, `OSS_ACT_PROCEED,
       8'h00, 10'h000, 8'h07, 24'h000001);
    wr(8'h07, 16'sh0046, 16'h0064, `OSS_OP_FIXED, 5'h11, 2'h2, 1'b1, `OSS_ACT_PROCEED,
       8'h0a, 10'h000, 8'h00, 24'h000001);
    wr(8'h0a, 16'sh0010, 16'h0064, `OSS_OP_FIXED, 5'h02, 2'h3, 1'b0, `OSS_ACT_PROCEED,
       8'h00, 10'h000, 8'h00, 24'h000001);
    wr(8'h0b, 16'sh0020, 16'h0064, `OSS_OP_FIXED, 5'h02, 2'h1, 1'b0, `OSS_ACT_PROCEED,
       8'h0a, 10'h001, 8'h00, 24'h000001);
    wr(8'h0c, 16'sh2000, 16'h0005, `OSS_OP_FIXED, 5'h03, 2'h2, 1'b0, `OSS_ACT_PROCEED,
       8'h00, 10'h000, 8'h00, 24'h000001);
    // Start with the output off is ignored, and so is hold in idle
    i_host.send(2'h0);
    repeat (3) @(negedge core_clk_i);
    chk(mode_o === 2'h0, "start taken while off");
    i_host.power(1'b1);
    i_host.send(2'h1);
    repeat (3) @(negedge core_clk_i);
    chk(mode_o === 2'h0, "hold taken in idle");
    // Start at step one, hold mid-step, resume exactly
    i_host.send(2'h0);
    t0 = cyc;
    repeat (3) @(negedge core_clk_i);
    chk(mode_o === 2'h1 && step_o === 8'h01 && sync_o === 2'h1, "start from idle");
    chk(dc_o === 16'sh0064 && freq_o === 16'h01f4 && wave_o === 5'h00, "fixed values");
    repeat (100) @(negedge core_clk_i);
    i_host.send(2'h1);
    repeat (50) @(negedge core_clk_i);
    chk(mode_o === 2'h2 && dc_o === 16'sh0064 && step_o === 8'h01, "hold state");
    i_host.send(2'h0);
    go(8'h02, 12000, n);
    n = cyc - t0 - held;
    chk(n >= 9996 && n <= 10006, "step time with hold");
    // Keep ignores programmed values except sync; branch out of the keep step
    repeat (3) @(negedge core_clk_i);
    chk(dc_o === 16'sh0064 && wave_o === 5'h00 && sync_o === 2'h2, "keep values");
    i_host.send(2'h3);
    go(8'h03, 8, n);
    // Branch target zero is refused; sweep of two ticks ramps from 100 to 300
    i_host.send(2'h3);
    repeat (3) @(negedge core_clk_i);
    chk(step_o === 8'h03, "branch to zero moved");
    repeat (14995) @(negedge core_clk_i);
    chk(dc_o >= 16'sh00c4 && dc_o <= 16'sh00cc, "sweep midpoint");
    repeat (5010) @(negedge core_clk_i);
    chk(mode_o === 2'h2 && dc_o === 16'sh012c, "end action hold");
    i_host.send(2'h0);
    go(8'h05, 8, n);
    repeat (3) @(negedge core_clk_i);
    chk(dc_o === 16'sh0032 && wave_o === 5'h01, "resume at jump target");
    // Branch mid-step
    repeat (10) @(negedge core_clk_i);
    i_host.send(2'h3);
    go(8'h07, 8, n);
    repeat (3) @(negedge core_clk_i);
    chk(wave_o === 5'h11 && sync_o === 2'h2, "user wave slot");
    // End-phase wait holds the step until zero phase
    repeat (10030) @(negedge core_clk_i);
    chk(step_o === 8'h07 && dc_o === 16'sh0046, "end phase wait");
    phase_zero_i = 1'b1;
    @(negedge core_clk_i);
    phase_zero_i = 1'b0;
    go(8'h0a, 10, n);
    repeat (3) @(negedge core_clk_i);
    chk(wave_o === 5'h02 && sync_o === 2'h3, "loop step values");
    // Loop of two steps runs jump count plus one times
    go(8'h0b, 12000, n);
    go(8'h0a, 12000, n);
    go(8'h0b, 12000, n);
    go(8'h0c, 12000, n);
    // Stop with out-of-range values
    repeat (3) @(negedge core_clk_i);
    i_host.send(2'h2);
    repeat (3) @(negedge core_clk_i);
    chk(mode_o === 2'h0 && step_o === 8'h00 && sync_o === 2'h0, "stop to idle");
    chk(wave_o === 5'h03 && phase_o === 12'h00c, "stop retains values");
    chk(dc_o === 16'sh0000 && ac_o === 16'h0000 && freq_o === 16'h000a, "clamp");
    chk(n_off == 1, "output off pulse");
    // End action idle beats the jump and keeps the present output
    wr(8'h01, 16'sh0064, 16'h01f4, `OSS_OP_FIXED, 5'h00, 2'h1, 1'b0, `OSS_ACT_IDLE,
       8'h05, 10'h000, 8'h00, 24'h000001);
    i_host.send(2'h0);
    go(8'h01, 8, n);
    go(8'h00, 12000, n);
    chk(mode_o === 2'h0 && sync_o === 2'h0 && dc_o === 16'sh0064, "end action idle");
    chk(freq_o === 16'h01f4 && n_off == 1, "idle keeps values");
    final_report;
  end
endmodule
